//--- pkg/dpr_pkg.sv
/*
 Constants, register map and carrier types for the drive PID regulator.
 Assumes a 20 MHz system clock and a classic Wishbone register port.
*/
package dpr_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
	localparam int TICK_MS_X100 = TICK_US / 10;
	localparam logic [15:0] TICK_CNT_MAX = 16'(TICK_CYC - 1);

	localparam logic [1:0] CFG_SPEED = 2'h1;
	localparam logic [1:0] CFG_PROCESS = 2'h3;

	// Word offsets on the bus (byte addresses)
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_UNIT = 8'h04;
	localparam logic [7:0] A_FBMIN = 8'h08;
	localparam logic [7:0] A_FBMAX = 8'h0c;
	localparam logic [7:0] A_REFMIN = 8'h10;
	localparam logic [7:0] A_REFMAX = 8'h14;
	localparam logic [7:0] A_BUSREF = 8'h18;
	localparam logic [7:0] A_KP = 8'h1c;
	localparam logic [7:0] A_TI = 8'h20;
	localparam logic [7:0] A_TD = 8'h24;
	localparam logic [7:0] A_DLIM = 8'h28;
	localparam logic [7:0] A_TF = 8'h2c;
	localparam logic [7:0] A_FMIN = 8'h30;
	localparam logic [7:0] A_FMAX = 8'h34;
	localparam logic [7:0] A_FSTART = 8'h38;
	localparam logic [7:0] A_STAT = 8'h3c;
	localparam logic [7:0] A_FOUT = 8'h40;
	localparam logic [7:0] A_REFRES = 8'h44;
	localparam logic [7:0] A_FBFILT = 8'h48;

	// CTRL fields
	localparam int C_CFG_LSB = 0;
	localparam int C_INV = 2;
	localparam int C_CWU = 3;
	localparam int C_RUN = 4;

	// Fixed-point scales: gains x1000, times in 0.01 ms, dlim x10
	localparam logic [31:0] KP_MAX = 32'h0000_03e8;
	localparam logic [31:0] KP_DEF = 32'h0000_000a;
	localparam logic [31:0] TI_MIN = 32'h0000_07d0;
	localparam logic [31:0] TI_DEF = 32'h0000_2710;
	localparam logic [31:0] TD_MAX = 32'h0000_4e20;
	localparam logic [31:0] TD_DEF = 32'h0000_07d0;
	localparam logic [31:0] DLIM_MIN = 32'h0000_0032;
	localparam logic [31:0] DLIM_MAX = 32'h0000_01f4;
	localparam logic [31:0] DLIM_DEF = 32'h0000_0032;
	localparam logic [31:0] TF_DEF = 32'h0000_2710;
	localparam logic [31:0] FMAX_DEF = 32'h0000_c350;
	localparam logic [31:0] FBMAX_DEF = 32'h0005_b8d8;
	localparam logic [31:0] KP_SCALE = 32'h0000_03e8;
	localparam logic [31:0] DLIM_SCALE = 32'h0000_000a;

	typedef enum logic [1:0] {DPR_IDLE, DPR_OPEN, DPR_CLOSED, DPR_HOLD} dpr_state_e;

	typedef struct packed {
		logic [1:0] cfg;
		logic inverse;
		logic cwu_en;
		logic run;
		logic [5:0] unit;
		logic signed [31:0] fb_min;
		logic signed [31:0] fb_max;
		logic signed [31:0] ref_min;
		logic signed [31:0] ref_max;
		logic signed [31:0] bus_ref;
		logic [31:0] kp;
		logic [31:0] ti;
		logic [31:0] td;
		logic [31:0] dlim;
		logic [31:0] tf;
		logic signed [31:0] f_min;
		logic signed [31:0] f_max;
		logic signed [31:0] f_start;
	} dpr_cfg_s;

	typedef struct packed {
		logic signed [31:0] preset;
		logic signed [31:0] volt;
		logic signed [31:0] curr;
		logic signed [31:0] pulse;
		logic volt_is_fb;
		logic curr_is_fb;
		logic pulse_is_fb;
		logic volt_is_ref;
		logic curr_is_ref;
		logic pulse_is_ref;
	} dpr_inputs_s;

	function automatic logic signed [31:0] dpr_clamp(input logic signed [31:0] v,
		input logic signed [31:0] lo, input logic signed [31:0] hi);
		dpr_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction
endpackage

//--- hw/dpr_lpf.sv
/*
 First-order low-pass filter on the feedback, one step per control tick.
 Assumes the tick is a one-cycle pulse on the same clock.
*/
`timescale 1ns/10ps
module dpr_lpf
	import dpr_pkg::*;
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// Filter control
	input wire logic i_tick,
	input wire logic [31:0] i_tf,
	input wire logic signed [31:0] i_x,
	// Filtered value
	output logic signed [31:0] o_y
);
	typedef struct packed {
		logic signed [31:0] y;
	} dpr_lpf_st_s;

	dpr_lpf_st_s st_r;
	dpr_lpf_st_s st_nxt;
	logic signed [63:0] step;

	// y += (x - y) * dt / tf, cutoff 1/tf rad/s; tf below one tick passes through
	always_comb
	begin
		st_nxt = st_r;
		step = 64'(i_x - st_r.y) * 64'(TICK_MS_X100);
		if (i_tick)
		begin
			if (i_tf <= 32'(TICK_MS_X100))
				st_nxt.y = i_x;
			else
				st_nxt.y = st_r.y + 32'(step / $signed({32'h0, i_tf}));
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign o_y = st_r.y;
endmodule // dpr_lpf

//--- hw/dpr_regulator.sv
/*
 Closed-loop PID regulator: reference summing, feedback filter, PID, start-up.
 Assumes a classic Wishbone master and same-clock measured inputs.
*/
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
module dpr_regulator
	import dpr_pkg::*;
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// Wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// Measured inputs and references
	input wire dpr_pkg::dpr_inputs_s i_in,
	// Limit flags from the drive
	input wire logic i_lim_cur,
	input wire logic i_lim_volt,
	// Output frequency request
	output logic signed [31:0] o_freq,
	output logic o_closed
);
	import dpr_pkg::*;

	typedef struct packed {
		dpr_cfg_s cfg;
		logic ack;
		logic [31:0] rdat;
		logic [15:0] tick_cnt;
		dpr_state_e state;
		logic signed [31:0] integ;
		logic signed [31:0] e_prev;
		logic signed [31:0] fout;
		logic signed [31:0] ref_res;
		logic cwu_hit;
	} dpr_st_s;

	dpr_st_s st_r;
	dpr_st_s st_nxt;
	logic tick;
	logic signed [31:0] fb_raw;
	logic signed [31:0] fb_f;
	logic signed [31:0] ref_sum;
	logic signed [31:0] ref_cl;
	logic signed [31:0] err;
	logic signed [63:0] p_term;
	logic signed [63:0] i_step;
	logic signed [63:0] d_raw;
	logic signed [63:0] d_cap;
	logic signed [63:0] d_term;
	logic signed [31:0] pid;
	logic at_limit;
	logic wb_req;
	logic spd;
	logic proc;

	function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		for (int b = 0; b < 4; b++)
			if (s[b])
				o[b*8 +: 8] = n[b*8 +: 8];
		wmask = o;
	endfunction

	function automatic logic signed [63:0] sat64(input logic signed [63:0] v, input logic signed [63:0] m);
		sat64 = (v > m) ? m : ((v < -m) ? -m : v);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Feedback and reference path
	assign tick = (st_r.tick_cnt == TICK_CNT_MAX);
	assign spd = (st_r.cfg.cfg == CFG_SPEED);
	assign proc = (st_r.cfg.cfg == CFG_PROCESS);

	always_comb
	begin
		fb_raw = '0;
		if (i_in.volt_is_fb)
			fb_raw = fb_raw + i_in.volt;
		if (i_in.curr_is_fb)
			fb_raw = fb_raw + i_in.curr;
		if (i_in.pulse_is_fb)
			fb_raw = fb_raw + i_in.pulse;
		ref_sum = i_in.preset + st_r.cfg.bus_ref;
		if (i_in.volt_is_ref && !i_in.volt_is_fb)
			ref_sum = ref_sum + i_in.volt;
		// A current feedback shuts out the current reference
		if (i_in.curr_is_ref && !i_in.curr_is_fb)
			ref_sum = ref_sum + i_in.curr;
		if (i_in.pulse_is_ref && !i_in.pulse_is_fb)
			ref_sum = ref_sum + i_in.pulse;
		// Reference window may be narrower than feedback range, never wider
		ref_cl = dpr_clamp(ref_sum, st_r.cfg.ref_min, st_r.cfg.ref_max);
		ref_cl = dpr_clamp(ref_cl, st_r.cfg.fb_min, st_r.cfg.fb_max);
	end

	dpr_lpf u_lpf
	(
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_tick(tick),
		.i_tf(st_r.cfg.tf),
		.i_x(fb_raw),
		.o_y(fb_f)
	);

	////////////////////////////////////////////////////////////////////////////
	// PID terms
	always_comb
	begin
		err = st_r.cfg.inverse ? (fb_f - st_r.ref_res) : (st_r.ref_res - fb_f);
		// Unsigned settings are widened and then taken as signed, so a negative error stays negative
		p_term = (64'(err) * $signed(64'(st_r.cfg.kp))) / $signed(64'(KP_SCALE));
		// Integral grows by P * dt / Ti per tick, so larger error integrates faster
		i_step = (p_term * 64'(TICK_MS_X100)) / $signed({32'h0, st_r.cfg.ti});
		d_raw = (p_term * $signed({32'h0, st_r.cfg.td})) / 64'(TICK_MS_X100)
			- (((64'(st_r.e_prev) * $signed(64'(st_r.cfg.kp))) / $signed(64'(KP_SCALE)))
			* $signed({32'h0, st_r.cfg.td}))
			/ 64'(TICK_MS_X100);
		// Bound the derivative to dlim times the proportional size of the error
		d_cap = ((p_term < 0 ? -p_term : p_term) * $signed({32'h0, st_r.cfg.dlim})) / $signed(64'(DLIM_SCALE));
		d_term = (st_r.cfg.td == '0) ? 64'sh0 : sat64(d_raw, d_cap);
		pid = 32'(p_term + 64'(st_r.integ) + i_step + d_term);
		at_limit = i_lim_cur || i_lim_volt || (st_r.fout >= st_r.cfg.f_max) || (st_r.fout <= st_r.cfg.f_min);
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus and regulator state
	assign wb_req = i_wb_cyc && i_wb_stb && !st_r.ack;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.ack = wb_req;
		st_nxt.tick_cnt = tick ? 16'h0 : st_r.tick_cnt + 16'h1;
		if (wb_req && i_wb_we)
		begin
			unique case (i_wb_adr)
				A_CTRL:
				begin
					st_nxt.cfg.cfg = i_wb_dat[C_CFG_LSB +: 2];
					st_nxt.cfg.inverse = i_wb_dat[C_INV];
					st_nxt.cfg.cwu_en = i_wb_dat[C_CWU];
					st_nxt.cfg.run = i_wb_dat[C_RUN];
				end
				A_UNIT: st_nxt.cfg.unit = i_wb_dat[5:0];
				A_FBMIN: st_nxt.cfg.fb_min = wmask(st_r.cfg.fb_min, i_wb_dat, i_wb_sel);
				A_FBMAX: st_nxt.cfg.fb_max = wmask(st_r.cfg.fb_max, i_wb_dat, i_wb_sel);
				A_REFMIN: st_nxt.cfg.ref_min = wmask(st_r.cfg.ref_min, i_wb_dat, i_wb_sel);
				A_REFMAX: st_nxt.cfg.ref_max = wmask(st_r.cfg.ref_max, i_wb_dat, i_wb_sel);
				A_BUSREF: st_nxt.cfg.bus_ref = wmask(st_r.cfg.bus_ref, i_wb_dat, i_wb_sel);
				A_KP: st_nxt.cfg.kp = (i_wb_dat > KP_MAX) ? KP_MAX : i_wb_dat;
				A_TI: st_nxt.cfg.ti = (i_wb_dat < TI_MIN) ? TI_MIN : i_wb_dat;
				A_TD: st_nxt.cfg.td = (i_wb_dat > TD_MAX) ? TD_MAX : i_wb_dat;
				A_DLIM: st_nxt.cfg.dlim = (i_wb_dat < DLIM_MIN) ? DLIM_MIN
					: ((i_wb_dat > DLIM_MAX) ? DLIM_MAX : i_wb_dat);
				A_TF: st_nxt.cfg.tf = wmask(st_r.cfg.tf, i_wb_dat, i_wb_sel);
				A_FMIN: st_nxt.cfg.f_min = wmask(st_r.cfg.f_min, i_wb_dat, i_wb_sel);
				A_FMAX: st_nxt.cfg.f_max = wmask(st_r.cfg.f_max, i_wb_dat, i_wb_sel);
				A_FSTART: st_nxt.cfg.f_start = wmask(st_r.cfg.f_start, i_wb_dat, i_wb_sel);
				default: ;
			endcase
		end
		unique case (i_wb_adr)
			A_CTRL: st_nxt.rdat = {27'h0, st_r.cfg.run, st_r.cfg.cwu_en, st_r.cfg.inverse, st_r.cfg.cfg};
			A_UNIT: st_nxt.rdat = {26'h0, st_r.cfg.unit};
			A_FBMIN: st_nxt.rdat = st_r.cfg.fb_min;
			A_FBMAX: st_nxt.rdat = st_r.cfg.fb_max;
			A_REFMIN: st_nxt.rdat = st_r.cfg.ref_min;
			A_REFMAX: st_nxt.rdat = st_r.cfg.ref_max;
			A_BUSREF: st_nxt.rdat = st_r.cfg.bus_ref;
			A_KP: st_nxt.rdat = st_r.cfg.kp;
			A_TI: st_nxt.rdat = st_r.cfg.ti;
			A_TD: st_nxt.rdat = st_r.cfg.td;
			A_DLIM: st_nxt.rdat = st_r.cfg.dlim;
			A_TF: st_nxt.rdat = st_r.cfg.tf;
			A_FMIN: st_nxt.rdat = st_r.cfg.f_min;
			A_FMAX: st_nxt.rdat = st_r.cfg.f_max;
			A_FSTART: st_nxt.rdat = st_r.cfg.f_start;
			A_STAT: st_nxt.rdat = {29'h0, st_r.cwu_hit, 2'(st_r.state)};
			A_FOUT: st_nxt.rdat = st_r.fout;
			A_REFRES: st_nxt.rdat = st_r.ref_res;
			A_FBFILT: st_nxt.rdat = fb_f;
			default: st_nxt.rdat = 32'h0;
		endcase

		if (tick)
		begin
			st_nxt.ref_res = ref_cl;
			st_nxt.e_prev = err;
			unique case (st_r.state)
				DPR_IDLE:
				begin
					st_nxt.fout = st_r.cfg.f_min;
					st_nxt.integ = st_r.cfg.f_min;
					if (st_r.cfg.run && (spd || proc))
						st_nxt.state = proc ? DPR_OPEN : DPR_CLOSED;
				end
				DPR_OPEN:
				begin
					// Open-loop ramp, one unit per tick; a current limit stalls it
					if (!i_lim_cur)
						st_nxt.fout = st_r.fout + 32'sh1;
					if (st_r.fout >= st_r.cfg.f_start)
					begin
						st_nxt.integ = st_r.fout;
						st_nxt.state = DPR_CLOSED;
					end
				end
				DPR_CLOSED:
				begin
					st_nxt.integ = 32'(64'(st_r.integ) + i_step);
					st_nxt.fout = dpr_clamp(pid, st_r.cfg.f_min, st_r.cfg.f_max);
					if (proc && st_r.cfg.cwu_en && at_limit)
					begin
						st_nxt.integ = st_r.fout;
						st_nxt.cwu_hit = 1'b1;
						st_nxt.state = DPR_HOLD;
					end
				end
				DPR_HOLD:
				begin
					// Regulator disengaged; output held where the last closed-loop tick left it
					if (err == 32'sh0 || (err[31] != st_r.e_prev[31]))
						st_nxt.state = DPR_CLOSED;
				end
			endcase
			if (!st_r.cfg.run || !(spd || proc))
				st_nxt.state = DPR_IDLE;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			st_r <= '0;
			st_r.cfg.kp <= KP_DEF;
			st_r.cfg.ti <= TI_DEF;
			st_r.cfg.td <= TD_DEF;
			st_r.cfg.dlim <= DLIM_DEF;
			st_r.cfg.tf <= TF_DEF;
			st_r.cfg.f_max <= FMAX_DEF;
			st_r.cfg.fb_max <= FBMAX_DEF;
			st_r.cfg.ref_max <= FBMAX_DEF;
			st_r.cfg.cwu_en <= 1'b1;
			st_r.state <= DPR_IDLE;
		end
		else
			st_r <= st_nxt;
	end

	assign o_wb_ack = st_r.ack;
	assign o_wb_dat = st_r.rdat;
	assign o_freq = st_r.fout;
	assign o_closed = (st_r.state == DPR_CLOSED);
endmodule // dpr_regulator

//--- sim/dpr_regulator_monitor.sv
/*
 Port checker for the PID regulator: bus handshake and output timing.
 Assumes one clock domain and an asynchronous active-high reset.
*/
`timescale 1ns/10ps
module dpr_monitor
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// Register bus
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	// Regulator output
	input wire logic signed [31:0] o_freq,
	input wire logic o_closed
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_sys_rst);
	////////////////////////////////////////////////////////////////////////////////
	a_ack_resp: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("bus request not answered in one cycle");
	a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property ($rose(o_wb_ack) |-> $past(i_wb_stb) && $past(i_wb_cyc))
		else $error("ack without request");
	a_hole_zero: assert property (i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack && i_wb_adr == 8'h4c
		|=> o_wb_dat == 32'h0) else $error("unmapped read not zero");
	// Output holds for at least eight cycles after each move
	a_freq_tick: assert property ($changed(o_freq) |=> $stable(o_freq) [*8])
		else $error("output changed twice within a tick");
	a_freq_floor: assert property (o_freq >= 32'sh0)
		else $error("output below zero");
	a_ramp_step: assert property ($changed(o_freq) && !o_closed && !$past(o_closed)
		&& $past(o_freq) != 32'sh0 && o_freq != 32'sh0 |-> o_freq == $past(o_freq) + 32'sh1)
		else $error("open-loop ramp step not one");
	a_closed_hold: assert property ($rose(o_closed) |=> o_closed [*8])
		else $error("closed loop dropped at once");
endmodule // dpr_monitor

//--- sim/dpr_plant.sv
/*
 Motor with feedback transmitter and reference sources.
 Assumes the regulator clock; feedback follows the request one cycle late.
*/
`timescale 1ns/10ps
module dpr_plant
	import dpr_pkg::*;
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	// Frequency request
	input wire logic signed [31:0] i_freq,
	// Measured values and limits
	output dpr_pkg::dpr_inputs_s o_in,
	output logic o_lim_cur,
	output logic o_lim_volt
);
	logic signed [31:0] speed_r;
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
		if (i_sys_rst)
			speed_r <= 32'sh0;
		else
			speed_r <= i_freq;
	always_comb
	begin
		o_in.preset = 32'sh3e8;
		o_in.volt = 32'sh1f4;
		// Offset keeps the current value nonzero so a wrongly used reference shows
		o_in.curr = speed_r + 32'sh64;
		o_in.pulse = 32'shc8;
		o_in.volt_is_fb = 1'b0;
		o_in.curr_is_fb = 1'b1;
		o_in.pulse_is_fb = 1'b1;
		o_in.volt_is_ref = 1'b1;
		o_in.curr_is_ref = 1'b1;
		o_in.pulse_is_ref = 1'b0;
	end
	// Bus reference is never offered here, only over the register port
	assign o_lim_cur = speed_r > 32'shc350;
	assign o_lim_volt = speed_r > 32'shc350;
endmodule // dpr_plant

//--- sim/test_drive_pid_regulator.sv
/*
 Self-checking bench for the PID regulator.
 Assumes the plant model and the port checker beside it.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
	$display("FAIL at %0t got %h expected %h", $time, (g), (e)); end end
module test_drive_pid_regulator;
	import dpr_pkg::*;
	logic i_sys_clk, i_sys_rst, cyc, stb, we, ack, closed, lim_c, lim_v;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, q;
	logic signed [31:0] freq;
	dpr_inputs_s in_s;
	int mismatches = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [7:0] da [9] = '{A_CTRL, A_KP, A_TI, A_TD, A_DLIM, A_TF, A_FMAX, A_FBMAX, A_REFMAX};
	logic [31:0] dv [9] = '{32'h8, KP_DEF, TI_DEF, TD_DEF, DLIM_DEF, TF_DEF, FMAX_DEF, FBMAX_DEF, FBMAX_DEF};
	logic [7:0] fa [15] = '{A_KP, A_KP, A_KP, A_TI, A_TI, A_TD, A_TD, A_TD, A_DLIM, A_DLIM, A_DLIM,
		A_UNIT, A_BUSREF, 8'h4c, A_FOUT};
	logic [31:0] fw [15] = '{32'h7d0, 32'h0, KP_DEF, 32'h5, TI_DEF, 32'h7530, 32'h0, TD_DEF, 32'h1,
		32'h270f, DLIM_DEF, 32'h29, 32'h7d0, 32'h5, 32'h5};
	logic [31:0] fe [15] = '{KP_MAX, 32'h0, KP_DEF, TI_MIN, TI_DEF, TD_MAX, 32'h0, TD_DEF, DLIM_MIN,
		DLIM_MAX, DLIM_DEF, 32'h29, 32'h7d0, 32'h0, 32'h0};
	initial
	begin
		i_sys_clk = 1'b0;
		forever #25 i_sys_clk = ~i_sys_clk;
	end
	dpr_regulator u_dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_in(in_s), .i_lim_cur(lim_c), .i_lim_volt(lim_v), .o_freq(freq), .o_closed(closed));
	dpr_plant u_plant (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_freq(freq), .o_in(in_s),
		.o_lim_cur(lim_c), .o_lim_volt(lim_v));
	////////////////////////////////////////////////////////////////////////////////
	task final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Five control ticks of 20000 cycles plus bus traffic end near 100300 cycles
	always @(posedge i_sys_clk)
	begin
		cycles++;
		if (cycles == 110000)
		begin
			mismatches++;
			final_report;
		end
	end
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge i_sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
		begin
			@(posedge i_sys_clk);
			n++;
		end
		while (ack !== 1'b1 && n < 40);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 40)
			mismatches++;
	endtask
	// Results refresh only on a tick, so poll up to about 1.3 ticks
	task poll(input logic [7:0] a, input logic [31:0] e);
		for (int k = 0; k < 250; k++)
		begin
			repeat (100) @(posedge i_sys_clk);
			wb(1'b0, a, 32'h0, q);
			if (q === e)
				break;
		end
	endtask
	task t_regs;
		for (int i = 0; i < 9; i++)
		begin
			wb(1'b0, da[i], 32'h0, q);
			`CHK(q, dv[i])
		end
		for (int i = 0; i < 15; i++)
		begin
			wb(1'b1, fa[i], fw[i], q);
			wb(1'b0, fa[i], 32'h0, q);
			`CHK(q, fe[i])
		end
	endtask
	task t_run;
		logic signed [31:0] f0;
		// Clamp checks ride on the ramp ticks; the plain sum is back when the loop closes
		wb(1'b1, A_FMIN, 32'h2, q);
		wb(1'b1, A_FSTART, 32'h3, q);
		wb(1'b1, A_REFMIN, 32'he10, q);
		wb(1'b1, A_CTRL, 32'h1b, q);
		poll(A_REFRES, 32'he10);
		`CHK(q, 32'he10)
		wb(1'b1, A_FBMAX, 32'hbb8, q);
		poll(A_REFRES, 32'hbb8);
		`CHK(q, 32'hbb8)
		wb(1'b1, A_REFMIN, 32'h0, q);
		wb(1'b1, A_FBMAX, FBMAX_DEF, q);
		poll(A_REFRES, 32'hdac);
		`CHK(q, 32'hdac)
		wb(1'b0, A_FBFILT, 32'h0, q);
		`CHK($signed(q) > 32'sh0 && $signed(q) < 32'sh12c, 1'b1)
		for (int k = 0; k < 80000 && closed !== 1'b1; k++)
			@(posedge i_sys_clk);
		`CHK(closed, 1'b1)
		`CHK(freq >= 32'sh3, 1'b1)
		f0 = freq;
		repeat (20100) @(posedge i_sys_clk);
		`CHK(freq > f0, 1'b1)
		f0 = freq;
		wb(1'b1, A_CTRL, 32'h1f, q);
		repeat (20100) @(posedge i_sys_clk);
		`CHK(freq < f0, 1'b1)
	endtask
	initial
	begin
		i_sys_rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h0;
		wdat = 32'h0;
		repeat (6) @(posedge i_sys_clk);
		i_sys_rst <= 1'b0;
		t_regs;
		t_run;
		final_report;
	end
endmodule // test_drive_pid_regulator
bind dpr_regulator dpr_monitor u_mon (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.o_freq(o_freq), .o_closed(o_closed));
